/* File: common/radio_core_regs.vh */
// register offsets, field positions and reset values of the radio core control bank
`ifndef RADIO_CORE_REGS_VH
`define RADIO_CORE_REGS_VH

// ****************************************
// register byte addresses
// ****************************************
`define OFS_CONTROL_TWO 32'h4000_0200
`define OFS_EXCHANGE_BASE 32'h4000_0208
`define OFS_DIAG_SELECT_UPPER 32'h4000_020c
`define OFS_EVENT_STATUS 32'h4000_0230
`define OFS_EVENT_MASK 32'h4000_0234

// ****************************************
// control two fields
// ****************************************
`define CLK_SEL_MSB 14
`define CLK_SEL_LSB 9
`define BIT_PWRDN_PERMITTED 8
`define BIT_SLOW_EDGE_MON 7
`define BIT_CLK_STATUS 6
`define BIT_DIAG_OVERRIDE 3
`define BIT_ERR_MASK 2
`define BIT_ERR_CLEAR 1
`define BIT_ERR_FLAG 0
`define ERR_MASK_RESET 1'h1

// ****************************************
// exchange base field
// ****************************************
`define EM_BASE_MSB 16
`define EM_BASE_LSB 10

// ****************************************
// diagnostic lanes: lane n (4..7) at base 8*(n-4)
// ****************************************
`define DIAG_EN_OFS 7
`define DIAG_SEL_WIDTH 6

// ****************************************
// event status / mask bits
// ****************************************
`define EV_SLOW_EDGE 0
`define EV_PWRDN_PERMITTED 1
`define EV_SLEEP_EXIT 2
`define EV_MEM_ERROR 3
`define EV_COUNT 4

// ****************************************
// timing
// ****************************************
`define PWRDN_SLOW_EDGES 4'h2

`endif

/* File: src/power_down_sequencer.v */
// slow-clock paced sequence that grants power down after a deep sleep request
`timescale 1ns/1ps
`include "radio_core_regs.vh"
module power_down_sequencer (
    // system
    input wire ref_clk_in,
    input wire rst_n_in,
    // events
    input wire slow_edge_in,
    input wire deep_sleep_request_in,
    input wire sleep_exit_interrupt_in,
    // result
    output wire power_down_permitted_out
);
    localparam [2:0] ST_AWAKE = 3'b001;
    localparam [2:0] ST_COUNT = 3'b010;
    localparam [2:0] ST_GRANTED = 3'b100;

    reg [2:0] state;
    reg [2:0] next_state;
    reg [3:0] edges;
    reg req_prev;

    // ****************************************
    // state machine
    // ****************************************
    always @* begin
        next_state = state;
        case (state)
            ST_AWAKE: begin
                if (deep_sleep_request_in && !req_prev) begin
                    next_state = ST_COUNT; // [R4]
                end
            end
            ST_COUNT: begin
                if (sleep_exit_interrupt_in) begin
                    next_state = ST_AWAKE;
                end else if (slow_edge_in && edges == `PWRDN_SLOW_EDGES - 4'h1) begin
                    next_state = ST_GRANTED; // [R4]
                end
            end
            ST_GRANTED: begin
                if (sleep_exit_interrupt_in) begin
                    next_state = ST_AWAKE; // [R5]
                end
            end
            default: next_state = ST_AWAKE;
        endcase
    end

    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= ST_AWAKE;
            edges <= 4'h0;
            req_prev <= 1'b0;
        end else begin
            state <= next_state;
            req_prev <= deep_sleep_request_in;
            if (state != ST_COUNT) begin
                edges <= 4'h0;
            end else if (slow_edge_in) begin
                edges <= edges + 4'h1;
            end
        end
    end

    assign power_down_permitted_out = state[2]; // [R3]
endmodule // power_down_sequencer

/* File: src/radio_core_control_regs.v */
// control and status register bank of the radio baseband core
//
// Functional notes
// [R1] clock select field holds master clock frequency in MHz, set by software
// [R2] software sets divider and frequency only before run enable is set
// [R3] read-only bit 8 shows power down is permitted, active high
// [R4] deep sleep request starts slow-clock sequence that grants power down
// [R5] power down grant clears when core exits sleep, with sleep exit interrupt
// [R6] bit 7 set on each slow clock rising edge; software may only clear
// [R7] edge monitor idle while slow timer held in reset
// [R8] bit 6 reads zero on slow clock, one on master clock
// [R9] bit 3 set overrides radio diagnostic output; clear passes it through
// [R10] error mask resets to one; gates error flag onto error interrupt
// [R11] writing one to clear bit drops error flag; bit reads zero
// [R12] bit 0 set on unmapped exchange page access; cleared only by clear bit
// [R13] bits 16:10 hold exchange memory base; other bits read zero
// [R14] lane enable cleared forces lane output zero, set passes selection
// [R15] 6-bit select picks signal group driving its lane when enabled
// [R16] lane 4 select sits in bits 5:0, honoured when lane 4 enabled
// [R17] reserved bits read zero, ignore writes; fields reset to listed values
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "radio_core_regs.vh"
module radio_core_control_regs (
    // system
    input wire ref_clk_in,
    input wire rst_n_in,
    // register port
    input wire [31:0] addr_in,
    input wire [31:0] wdata_in,
    input wire write_in,
    input wire read_in,
    output reg [31:0] rdata_out,
    // radio core status
    input wire slow_clk_in,
    input wire slow_timer_reset_in,
    input wire deep_sleep_request_in,
    input wire sleep_exit_interrupt_in,
    input wire master_clock_active_in,
    input wire memory_access_error_event_in,
    // radio core controls
    output wire [5:0] master_clock_mhz_out,
    output wire power_down_permitted_out,
    output wire [6:0] exchange_base_address_field_out,
    // diagnostics
    input wire [7:0] radio_diagnostic_output_in,
    input wire [63:0] diag_signal_groups_in,
    output reg [7:0] diag_port_out,
    // interrupts
    output wire error_irq_out,
    output wire event_irq_out
);
    // ****************************************
    // storage
    // ****************************************
    reg [5:0] clk_sel;
    reg slow_clock_edge_monitor;
    reg diagnostic_override;
    reg memory_access_error_mask;
    reg memory_access_error_flag;
    reg [6:0] exchange_base;
    reg [31:0] diag_select_upper;
    reg [`EV_COUNT-1:0] event_status;
    reg [`EV_COUNT-1:0] event_mask;
    reg permitted_prev;
    reg [31:0] next_rdata;
    reg [`EV_COUNT-1:0] next_status;

    wire slow_edge;
    wire power_down_permitted;
    wire hit_ctl;
    wire hit_base;
    wire hit_diag;
    wire hit_status;
    wire hit_mask;
    wire [3:0] lane_bits;
    wire [`EV_COUNT-1:0] events;

    assign hit_ctl = (addr_in == `OFS_CONTROL_TWO);
    assign hit_base = (addr_in == `OFS_EXCHANGE_BASE);
    assign hit_diag = (addr_in == `OFS_DIAG_SELECT_UPPER);
    assign hit_status = (addr_in == `OFS_EVENT_STATUS);
    assign hit_mask = (addr_in == `OFS_EVENT_MASK);

    // ****************************************
    // slow clock monitor and power down sequence
    // ****************************************
    slow_edge_detect u_edge (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .slow_clk_in(slow_clk_in),
        .slow_timer_reset_in(slow_timer_reset_in),
        .slow_edge_out(slow_edge)
    );

    power_down_sequencer u_seq (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .slow_edge_in(slow_edge),
        .deep_sleep_request_in(deep_sleep_request_in),
        .sleep_exit_interrupt_in(sleep_exit_interrupt_in),
        .power_down_permitted_out(power_down_permitted)
    );

    assign power_down_permitted_out = power_down_permitted; // [R3]

    // ****************************************
    // register writes
    // ****************************************
    // the frequency field is not guarded: software must leave it alone once running
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            clk_sel <= 6'h0; // [R17]
            slow_clock_edge_monitor <= 1'b0;
            diagnostic_override <= 1'b0;
            memory_access_error_mask <= `ERR_MASK_RESET; // [R10]
            memory_access_error_flag <= 1'b0;
            exchange_base <= 7'h0;
            diag_select_upper <= 32'h0000_0000;
            event_mask <= {`EV_COUNT{1'b0}};
        end else begin
            if (write_in && hit_ctl) begin
                clk_sel <= wdata_in[`CLK_SEL_MSB:`CLK_SEL_LSB]; // [R1] [R2]
                diagnostic_override <= wdata_in[`BIT_DIAG_OVERRIDE];
                memory_access_error_mask <= wdata_in[`BIT_ERR_MASK];
            end else if (write_in && hit_base) begin
                exchange_base <= wdata_in[`EM_BASE_MSB:`EM_BASE_LSB]; // [R13]
            end else if (write_in && hit_diag) begin
                // reserved bits 30, 22, 14 and 6 are never stored
                diag_select_upper <= wdata_in & 32'hbfbf_bfbf; // [R16] [R17]
            end else if (write_in && hit_mask) begin
                event_mask <= wdata_in[`EV_COUNT-1:0];
            end
            // an edge in the same cycle as a clearing write still sets the bit
            if (slow_edge) begin
                slow_clock_edge_monitor <= 1'b1; // [R6]
            end else if (write_in && hit_ctl && !wdata_in[`BIT_SLOW_EDGE_MON]) begin
                slow_clock_edge_monitor <= 1'b0; // [R6]
            end
            if (memory_access_error_event_in) begin
                memory_access_error_flag <= 1'b1; // [R12]
            end else if (write_in && hit_ctl && wdata_in[`BIT_ERR_CLEAR]) begin
                memory_access_error_flag <= 1'b0; // [R11]
            end
        end
    end

    // ****************************************
    // event status, cleared by reading it
    // ****************************************
    assign events[`EV_SLOW_EDGE] = slow_edge;
    assign events[`EV_PWRDN_PERMITTED] = power_down_permitted & ~permitted_prev;
    assign events[`EV_SLEEP_EXIT] = sleep_exit_interrupt_in;
    assign events[`EV_MEM_ERROR] = memory_access_error_event_in;

    always @* begin
        next_status = event_status;
        if (read_in && hit_status) begin
            next_status = {`EV_COUNT{1'b0}};
        end
        next_status = next_status | events;
    end

    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            event_status <= {`EV_COUNT{1'b0}};
            permitted_prev <= 1'b0;
        end else begin
            event_status <= next_status;
            permitted_prev <= power_down_permitted;
        end
    end

    assign event_irq_out = |(event_status & event_mask);
    assign error_irq_out = memory_access_error_flag & memory_access_error_mask; // [R10]

    // ****************************************
    // read path, data one cycle after the strobe
    // ****************************************
    always @* begin
        next_rdata = 32'h0000_0000;
        if (hit_ctl) begin
            next_rdata[`CLK_SEL_MSB:`CLK_SEL_LSB] = clk_sel;
            next_rdata[`BIT_PWRDN_PERMITTED] = power_down_permitted; // [R3]
            next_rdata[`BIT_SLOW_EDGE_MON] = slow_clock_edge_monitor;
            next_rdata[`BIT_CLK_STATUS] = master_clock_active_in; // [R8]
            next_rdata[`BIT_DIAG_OVERRIDE] = diagnostic_override;
            next_rdata[`BIT_ERR_MASK] = memory_access_error_mask;
            next_rdata[`BIT_ERR_CLEAR] = 1'b0; // [R11]
            next_rdata[`BIT_ERR_FLAG] = memory_access_error_flag;
        end else if (hit_base) begin
            next_rdata[`EM_BASE_MSB:`EM_BASE_LSB] = exchange_base; // [R13]
        end else if (hit_diag) begin
            next_rdata = diag_select_upper;
        end else if (hit_status) begin
            next_rdata[`EV_COUNT-1:0] = event_status;
        end else if (hit_mask) begin
            next_rdata[`EV_COUNT-1:0] = event_mask;
        end
    end

    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_out <= 32'h0000_0000;
        end else if (read_in) begin
            rdata_out <= next_rdata; // [R17]
        end else begin
            rdata_out <= 32'h0000_0000;
        end
    end

    // ****************************************
    // diagnostic lanes 4 to 7
    // ****************************************
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
            wire lane_en;
            wire [5:0] lane_sel;
            assign lane_en = diag_select_upper[lane*8+`DIAG_EN_OFS];
            assign lane_sel = diag_select_upper[lane*8+5:lane*8];
            assign lane_bits[lane] = lane_en & diag_signal_groups_in[lane_sel]; // [R14] [R15]
        end
    endgenerate

    // override puts the lane selections on the upper half and quiets the lower
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            diag_port_out <= 8'h00;
        end else if (diagnostic_override) begin
            diag_port_out <= {lane_bits, 4'h0}; // [R9]
        end else begin
            diag_port_out <= radio_diagnostic_output_in; // [R9]
        end
    end

    assign master_clock_mhz_out = clk_sel; // [R1]
    assign exchange_base_address_field_out = exchange_base;
endmodule // radio_core_control_regs

/* File: src/slow_edge_detect.v */
// synchroniser and rising edge monitor for the low-power timer clock
`timescale 1ns/1ps
module slow_edge_detect (
    // system
    input wire ref_clk_in,
    input wire rst_n_in,
    // slow clock side
    input wire slow_clk_in,
    input wire slow_timer_reset_in,
    // result
    output wire slow_edge_out
);
    reg sync_a;
    reg sync_b;
    reg sync_c;

    // ****************************************
    // two-stage synchroniser, edge taken past it
    // ****************************************
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            sync_c <= 1'b0;
        end else begin
            sync_a <= slow_clk_in;
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    // monitor silent while the slow timer sits in reset
    assign slow_edge_out = sync_b & ~sync_c & ~slow_timer_reset_in; // [R7]
endmodule // slow_edge_detect

/* File: verif/radio_core_control_regs_assertions.sv */
// assertion checker for the radio core control register bank
`timescale 1ns/1ps
`include "radio_core_regs.vh"
module radio_core_control_regs_assertions (
    // system
    input wire ref_clk_in,
    input wire rst_n_in,
    // register port
    input wire [31:0] addr_in,
    input wire [31:0] wdata_in,
    input wire write_in,
    input wire read_in,
    input wire [31:0] rdata_out,
    // core side
    input wire sleep_exit_interrupt_in,
    input wire memory_access_error_event_in,
    input wire [5:0] master_clock_mhz_out,
    input wire power_down_permitted_out,
    input wire [6:0] exchange_base_address_field_out,
    input wire error_irq_out
);
    // ****
    // helpers
    // ****
    wire ctl_wr = write_in && (addr_in == `OFS_CONTROL_TWO);
    wire base_wr = write_in && (addr_in == `OFS_EXCHANGE_BASE);
    wire [5:0] wr_mhz = wdata_in[14:9];
    wire [6:0] wr_base = wdata_in[16:10];
    wire mapped = (addr_in == `OFS_CONTROL_TWO) || (addr_in == `OFS_EXCHANGE_BASE) ||
        (addr_in == `OFS_DIAG_SELECT_UPPER) || (addr_in == `OFS_EVENT_STATUS) ||
        (addr_in == `OFS_EVENT_MASK);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    // ****
    // properties
    // ****
    property p_rdata_quiet; !$past(read_in) |-> rdata_out == 32'h0000_0000; endproperty
    a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data outside answer");
    property p_unmapped; read_in && !mapped |=> rdata_out == 32'h0000_0000; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_mhz; ctl_wr |=> master_clock_mhz_out == $past(wr_mhz); endproperty
    a_mhz: assert property (p_mhz) else $error("clock select not written");
    property p_mhz_hold; !ctl_wr |=> $stable(master_clock_mhz_out); endproperty
    a_mhz_hold: assert property (p_mhz_hold) else $error("clock select moved");
    property p_base; base_wr |=> exchange_base_address_field_out == $past(wr_base); endproperty
    a_base: assert property (p_base) else $error("base field not written");
    property p_mask_off; ctl_wr && !wdata_in[2] |=> !error_irq_out; endproperty
    a_mask_off: assert property (p_mask_off) else $error("masked error irq");
    property p_ack;
        ctl_wr && wdata_in[1] && !memory_access_error_event_in |=> !error_irq_out;
    endproperty
    a_ack: assert property (p_ack) else $error("error irq after clear");
    property p_err_rise;
        $rose(error_irq_out) |-> $past(memory_access_error_event_in) || $past(ctl_wr);
    endproperty
    a_err_rise: assert property (p_err_rise) else $error("error irq without cause");
    property p_err_fall; $fell(error_irq_out) |-> $past(ctl_wr); endproperty
    a_err_fall: assert property (p_err_fall) else $error("error irq dropped alone");
    property p_exit; sleep_exit_interrupt_in |=> !power_down_permitted_out; endproperty
    a_exit: assert property (p_exit) else $error("grant kept after exit");
    property p_grant_fall; $fell(power_down_permitted_out) |-> $past(sleep_exit_interrupt_in);
    endproperty
    a_grant_fall: assert property (p_grant_fall) else $error("grant dropped alone");
endmodule // radio_core_control_regs_assertions

bind radio_core_control_regs radio_core_control_regs_assertions i_chk (.ref_clk_in, .rst_n_in,
    .addr_in, .wdata_in, .write_in, .read_in, .rdata_out, .sleep_exit_interrupt_in,
    .memory_access_error_event_in, .master_clock_mhz_out, .power_down_permitted_out,
    .exchange_base_address_field_out, .error_irq_out);

/* File: verif/testbench.sv */
// self-checking testbench of the radio core control register bank
`timescale 1ns/1ps
`include "radio_core_regs.vh"
module testbench;
    // ****
    // signals
    // ****
    localparam logic [31:0] ctl = `OFS_CONTROL_TWO;
    localparam logic [31:0] all = 32'hffff_ffff;
    logic ref_clk_in = 1'b0, rst_n_in = 1'b0, write_in = 1'b0, read_in = 1'b0;
    logic [31:0] addr_in = 32'h0000_0000, wdata_in = 32'h0000_0000, rdata_out, rd;
    logic slow_clk_in = 1'b0, slow_timer_reset_in = 1'b0, deep_sleep_request_in = 1'b0;
    logic sleep_exit_interrupt_in = 1'b0, master_clock_active_in = 1'b0;
    logic memory_access_error_event_in = 1'b0;
    logic [5:0] master_clock_mhz_out;
    logic power_down_permitted_out, error_irq_out, event_irq_out;
    logic [6:0] exchange_base_address_field_out;
    logic [7:0] radio_diagnostic_output_in = 8'h00, diag_port_out;
    logic [63:0] diag_signal_groups_in = 64'h0000_0000_0000_0000;
    logic [31:0] rows [11][3];
    int err_total = 0;
    int n_checks = 0;

    radio_core_control_regs i_dut (.ref_clk_in, .rst_n_in, .addr_in, .wdata_in, .write_in,
        .read_in, .rdata_out, .slow_clk_in, .slow_timer_reset_in, .deep_sleep_request_in,
        .sleep_exit_interrupt_in, .master_clock_active_in, .memory_access_error_event_in,
        .master_clock_mhz_out, .power_down_permitted_out, .exchange_base_address_field_out,
        .radio_diagnostic_output_in, .diag_signal_groups_in, .diag_port_out, .error_irq_out,
        .event_irq_out);

    initial begin
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    // ****
    // tasks
    // ****
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        addr_in <= a;
        wdata_in <= d;
        write_in <= 1'b1;
        @(posedge ref_clk_in);
        write_in <= 1'b0;
    endtask
    // masked read compare; answer only stands one cycle, so sample it there
    task automatic rdc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] exp);
        @(posedge ref_clk_in);
        addr_in <= a;
        read_in <= 1'b1;
        @(posedge ref_clk_in);
        read_in <= 1'b0;
        #1 rd = rdata_out;
        chk(rd & m, exp);
    endtask
    // slow clock only moves inside a pulse, still otherwise
    task automatic slow_pulse(input logic hold);
        @(posedge ref_clk_in);
        slow_timer_reset_in <= hold;
        slow_clk_in <= 1'b1;
        cyc(5);
        slow_clk_in <= 1'b0;
        cyc(5);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        cyc(3000);
        err_total++;
        end_sim();
    end
    // ****
    // main sequence
    // ****
    initial begin
        rows = '{'{ctl, all, 32'h0000_7e0c}, '{ctl, 32'h0000_1000, 32'h0000_1000},
            '{ctl, 32'h0000_1004, 32'h0000_1004}, '{32'h4000_0208, all, 32'h0001_fc00},
            '{32'h4000_0208, 32'h0000_0400, 32'h0000_0400}, '{32'h4000_020c, all, 32'hbfbf_bfbf},
            '{32'h4000_020c, 32'h4040_4040, 32'h0}, '{32'h4000_0204, all, 32'h0},
            '{32'h4000_0234, all, 32'h0000_000f}, '{32'h4000_0234, 32'h8, 32'h8},
            '{32'h4000_0230, all, 32'h0}};
        cyc(16);
        rst_n_in <= 1'b1;
        rdc(ctl, all, 32'h0000_0004);
        rdc(32'h4000_0208, all, 32'h0);
        rdc(32'h4000_020c, all, 32'h0);
        for (int i = 0; i < 11; i++) begin
            wr(rows[i][0], rows[i][1]);
            rdc(rows[i][0], all, rows[i][2]);
        end
        chk(32'(master_clock_mhz_out), 32'h0000_0008);
        chk(32'(exchange_base_address_field_out), 32'h0000_0001);
        // error flag, mask and clear; later control writes keep the 8 MHz field
        @(posedge ref_clk_in);
        memory_access_error_event_in <= 1'b1;
        @(posedge ref_clk_in);
        memory_access_error_event_in <= 1'b0;
        #1 chk(32'(error_irq_out), 32'h1);
        chk(32'(event_irq_out), 32'h1);
        wr(ctl, 32'h0000_1004);
        rdc(ctl, 32'h0000_0003, 32'h0000_0001);
        wr(ctl, 32'h0000_1000);
        #1 chk(32'(error_irq_out), 32'h0);
        rdc(32'h4000_0230, 32'h8, 32'h8);
        chk(32'(event_irq_out), 32'h0);
        wr(ctl, 32'h0000_1004);
        #1 chk(32'(error_irq_out), 32'h1);
        wr(ctl, 32'h0000_1006);
        #1 chk(32'(error_irq_out), 32'h0);
        rdc(ctl, 32'h0000_0003, 32'h0);
        // slow edge monitor, gated while the slow timer is in reset
        slow_pulse(1'b1);
        rdc(ctl, 32'h80, 32'h0);
        slow_pulse(1'b0);
        rdc(ctl, 32'h80, 32'h80);
        wr(ctl, 32'h0000_1084);
        rdc(ctl, 32'h80, 32'h80);
        wr(ctl, 32'h0000_1004);
        rdc(ctl, 32'h80, 32'h0);
        chk(32'(master_clock_mhz_out), 32'h0000_0008);
        @(posedge ref_clk_in);
        master_clock_active_in <= 1'b1;
        rdc(ctl, 32'h40, 32'h40);
        // power down grant after deep sleep request
        @(posedge ref_clk_in);
        deep_sleep_request_in <= 1'b1;
        rdc(ctl, 32'h100, 32'h0);
        slow_pulse(1'b0);
        slow_pulse(1'b0);
        rdc(ctl, 32'h100, 32'h100);
        chk(32'(power_down_permitted_out), 32'h1);
        @(posedge ref_clk_in);
        sleep_exit_interrupt_in <= 1'b1;
        @(posedge ref_clk_in);
        sleep_exit_interrupt_in <= 1'b0;
        deep_sleep_request_in <= 1'b0;
        #1 chk(32'(power_down_permitted_out), 32'h0);
        rdc(ctl, 32'h100, 32'h0);
        rdc(32'h4000_0230, all, 32'h0000_0007);
        // diagnostic pass-through and override
        @(posedge ref_clk_in);
        radio_diagnostic_output_in <= 8'ha5;
        diag_signal_groups_in <= 64'h8000_0000_0000_0021;
        cyc(2);
        #1 chk(32'(diag_port_out), 32'h0000_00a5);
        wr(32'h4000_020c, 32'h8a00_bf85);
        wr(ctl, 32'h0000_100c);
        cyc(2);
        #1 chk(32'(diag_port_out), 32'h0000_0030);
        @(posedge ref_clk_in);
        diag_signal_groups_in <= 64'h8000_0000_0000_0421;
        cyc(2);
        #1 chk(32'(diag_port_out), 32'h0000_00b0);
        // mid-run reset brings every field back to its reset value
        @(posedge ref_clk_in);
        rst_n_in <= 1'b0;
        cyc(3);
        rst_n_in <= 1'b1;
        rdc(ctl, all, 32'h0000_0044);
        rdc(32'h4000_020c, all, 32'h0);
        rdc(32'h4000_0234, all, 32'h0);
        chk(32'(master_clock_mhz_out), 32'h0);
        end_sim();
    end
endmodule // testbench
